// >>> elc_params.svh
// Register offsets, field positions, reset values and bus constants of the event log control block
`ifndef ELC_PARAMS_SVH
`define ELC_PARAMS_SVH

// Register offsets are word indices; the byte address is four times the index
`define ELC_IDX_CTRL      20'h48000
`define ELC_IDX_TSEL      20'h48004
`define ELC_IDX_THRESH    20'h4800C
`define ELC_IDX_PTR       20'h4800E
`define ELC_IDX_CH_ON     20'h48020
`define ELC_IDX_CH_LVL    20'h48024
`define ELC_IDX_IRQ_STS   20'h48030
`define ELC_IDX_IRQ_MASK  20'h48034

// Field positions
`define ELC_CTRL_ON_BIT   0
`define ELC_CTRL_CLR_BIT  1
`define ELC_PTR_NE_BIT    16
`define ELC_PTR_WM_BIT    17
`define ELC_PTR_FULL_BIT  18

// Reset values, timestamp source code and queue depth
`define ELC_TSEL_RST      2'h0
`define ELC_TSEL_TIMER1   2'h0
`define ELC_THRESH_RST    4'h1
`define ELC_QUEUE_DEPTH   5'h10

// Bus widths
`define ELC_AW            24
`define ELC_DW            32

`endif

// >>> elc_pkg.sv
// Types shared by the event log control block
package elc_pkg;

  // One logged event handed to the queue storage
  typedef struct packed {
    logic       valid;   // One-cycle store strobe
    logic [3:0] index;   // Queue slot to write
    logic [3:0] channel; // Channel number
  } elc_log_t;

  // Sticky interrupt causes, same layout in status and mask registers
  typedef struct packed {
    logic full;
    logic thresh;
    logic unread;
  } elc_irq_t;

endpackage : elc_pkg

// >>> elc_regs.sv
// Event log control and status register bank with channel arbitration and queue pointers
`timescale 1ns/10ps
`include "elc_params.svh"

// Functional notes
// - Clear bit write empties queue and flags
// - Recorder logs only while enable bit set
// - Timestamp source code 00 only, others reserved
// - Four-bit free space threshold, resets to one
// - Threshold flag when free slots <= threshold
// - Full flag set when all slots unread
// - Unread flag while any event unconsumed
// - Read-only write index of next slot
// - Sixteen channel enable bits, reset zero
// - Sixteen read-only channel level bits
// - While full, new events are discarded
// - One event per cycle, lowest channel wins
module elc_regs (
  input  wire logic                SYS_CLK,  // Logger clock
  input  wire logic                NRST,     // Asynchronous reset, active low
  input  wire logic                PSEL,     // APB select
  input  wire logic                PENABLE,  // APB access phase
  input  wire logic                PWRITE,   // APB direction
  input  wire logic [`ELC_AW-1:0]  PADDR,    // APB byte address
  input  wire logic [`ELC_DW-1:0]  PWDATA,   // APB write data
  output logic      [`ELC_DW-1:0]  PRDATA,   // APB read data
  output logic                     PREADY,   // APB ready
  output logic                     PSLVERR,  // APB error on unmapped address
  input  wire logic [15:0]         CH_SRC,   // Selected source levels, asynchronous
  output logic      [15:0]         CH_ON,    // Channel enables to source logic
  output logic      [1:0]          TS_SEL,   // Timestamp source select
  output elc_pkg::elc_log_t        LOG,      // Store strobe for queue storage
  output logic                     IRQ       // Level interrupt
);
  import elc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [`ELC_AW-1:0] a, input logic [19:0] idx);
    hit = (a == {2'h0, idx, 2'h0});
  endfunction : hit

  function automatic logic [4:0] lowest(input logic [15:0] v);
    lowest = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        lowest = 5'(i);
      end
    end
  endfunction : lowest

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] sync1_ff, sync2_ff, prev_ff, pend_ff, nxt_pend;
  logic        on_ff, full_ff, wm_ff, ne_ff, nxt_full;
  logic [1:0]  tsel_ff;
  logic [3:0]  thresh_ff, wptr_ff, rptr_ff;
  logic [15:0] ch_on_ff, lvl_ff;
  logic [`ELC_DW-1:0] prdata_ff;
  logic        pready_ff, pslverr_ff, irq_ff;
  elc_log_t    log_ff;
  elc_irq_t    sts_ff, mask_ff, flag_prev_ff, flags;
  logic        setup, wr_acc, clr, rptr_wr, store, mapped;
  logic [4:0]  win, unread, free_slots;
  logic [15:0] edges;

  assign setup   = PSEL & ~PENABLE;
  assign wr_acc  = PSEL & PENABLE & PWRITE & pready_ff;
  assign clr     = wr_acc & hit(PADDR, `ELC_IDX_CTRL) & PWDATA[`ELC_CTRL_CLR_BIT];
  assign rptr_wr = wr_acc & hit(PADDR, `ELC_IDX_PTR) & (PWDATA[3:0] != rptr_ff);
  assign mapped  = hit(PADDR, `ELC_IDX_CTRL) | hit(PADDR, `ELC_IDX_TSEL)
                 | hit(PADDR, `ELC_IDX_THRESH) | hit(PADDR, `ELC_IDX_PTR)
                 | hit(PADDR, `ELC_IDX_CH_ON) | hit(PADDR, `ELC_IDX_CH_LVL)
                 | hit(PADDR, `ELC_IDX_IRQ_STS) | hit(PADDR, `ELC_IDX_IRQ_MASK);

  // ----------------------------------------------------------------
  // Queue occupancy
  // ----------------------------------------------------------------
  // Equal pointers are ambiguous, so the full flag breaks the tie
  assign unread     = full_ff ? `ELC_QUEUE_DEPTH : {1'b0, 4'(wptr_ff - rptr_ff)};
  assign free_slots = 5'(`ELC_QUEUE_DEPTH - unread);

  // ----------------------------------------------------------------
  // Input synchroniser and channel level mirror
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sync1_ff <= 16'h0000;
      sync2_ff <= 16'h0000;
      lvl_ff   <= 16'h0000;
    end else begin
      sync1_ff <= CH_SRC;
      sync2_ff <= sync1_ff;
      lvl_ff   <= sync2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Event detection and arbitration
  // ----------------------------------------------------------------
  // Previous level is held low while off, so a level already high at enable logs once
  assign edges = sync2_ff & ~prev_ff & ch_on_ff;
  assign win   = lowest(pend_ff);
  assign store = on_ff & ~full_ff & ~win[4] & ~clr;

  always_comb begin
    nxt_pend = pend_ff & ch_on_ff;
    if (store) begin
      nxt_pend[win[3:0]] = 1'b0;
    end
    // Events seen while full are dropped; a repeat of a pending one merges
    if (!full_ff) begin
      nxt_pend = nxt_pend | edges;
    end
    if (!on_ff || clr) begin
      nxt_pend = 16'h0000;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      prev_ff <= 16'h0000;
      pend_ff <= 16'h0000;
      log_ff  <= '0;
    end else begin
      prev_ff <= on_ff ? sync2_ff : 16'h0000;
      pend_ff <= nxt_pend;
      log_ff  <= '{valid: store, index: wptr_ff, channel: win[3:0]};
    end
  end

  // ----------------------------------------------------------------
  // Pointers and flags
  // ----------------------------------------------------------------
  always_comb begin
    nxt_full = full_ff;
    if (rptr_wr) begin
      nxt_full = 1'b0;
    end
    // A store that fills the last slot wins over a read index update
    if (store && (4'(wptr_ff + 4'h1) == rptr_ff)) begin
      nxt_full = 1'b1;
    end
    if (clr) begin
      nxt_full = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      wptr_ff <= 4'h0;
      rptr_ff <= 4'h0;
      full_ff <= 1'b0;
      wm_ff   <= 1'b0;
      ne_ff   <= 1'b0;
    end else begin
      full_ff <= nxt_full;
      if (clr) begin
        wptr_ff <= 4'h0;
        rptr_ff <= 4'h0;
        wm_ff   <= 1'b0;
        ne_ff   <= 1'b0;
      end else begin
        if (store) begin
          wptr_ff <= 4'(wptr_ff + 4'h1);
        end
        if (wr_acc && hit(PADDR, `ELC_IDX_PTR)) begin
          rptr_ff <= PWDATA[3:0];
        end
        wm_ff <= (free_slots <= {1'b0, thresh_ff});
        ne_ff <= (unread != 5'h00);
      end
    end
  end

  // ----------------------------------------------------------------
  // Software control registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      on_ff     <= 1'b0;
      tsel_ff   <= `ELC_TSEL_RST;
      thresh_ff <= `ELC_THRESH_RST;
      ch_on_ff  <= 16'h0000;
      mask_ff   <= '0;
    end else if (wr_acc) begin
      if (hit(PADDR, `ELC_IDX_CTRL)) begin
        on_ff <= PWDATA[`ELC_CTRL_ON_BIT];
      end
      // Reserved codes and writes while running are ignored
      if (hit(PADDR, `ELC_IDX_TSEL) && !on_ff
          && PWDATA[1:0] == `ELC_TSEL_TIMER1) begin
        tsel_ff <= PWDATA[1:0];
      end
      if (hit(PADDR, `ELC_IDX_THRESH)) begin
        thresh_ff <= PWDATA[3:0];
      end
      if (hit(PADDR, `ELC_IDX_CH_ON)) begin
        ch_on_ff <= PWDATA[15:0];
      end
      if (hit(PADDR, `ELC_IDX_IRQ_MASK)) begin
        mask_ff <= elc_irq_t'(PWDATA[2:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  assign flags = '{full: full_ff, thresh: wm_ff, unread: ne_ff};

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sts_ff       <= '0;
      flag_prev_ff <= '0;
      irq_ff       <= 1'b0;
    end else begin
      flag_prev_ff <= flags;
      // A rising flag in the clearing cycle survives the write-one clear
      if (wr_acc && hit(PADDR, `ELC_IDX_IRQ_STS)) begin
        sts_ff <= (sts_ff & ~elc_irq_t'(PWDATA[2:0])) | (flags & ~flag_prev_ff);
      end else begin
        sts_ff <= sts_ff | (flags & ~flag_prev_ff);
      end
      irq_ff <= |(sts_ff & mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait-free access phase, data captured at setup
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff  <= 32'h00000000;
      if (setup && !PWRITE) begin
        if (hit(PADDR, `ELC_IDX_CTRL)) begin
          prdata_ff <= {31'h0, on_ff};
        end
        if (hit(PADDR, `ELC_IDX_TSEL)) begin
          prdata_ff <= {30'h0, tsel_ff};
        end
        if (hit(PADDR, `ELC_IDX_THRESH)) begin
          prdata_ff <= {28'h0, thresh_ff};
        end
        if (hit(PADDR, `ELC_IDX_PTR)) begin
          prdata_ff <= {13'h0, full_ff, wm_ff, ne_ff, 4'h0, wptr_ff, 4'h0, rptr_ff};
        end
        if (hit(PADDR, `ELC_IDX_CH_ON)) begin
          prdata_ff <= {16'h0000, ch_on_ff};
        end
        if (hit(PADDR, `ELC_IDX_CH_LVL)) begin
          prdata_ff <= {16'h0000, lvl_ff};
        end
        if (hit(PADDR, `ELC_IDX_IRQ_STS)) begin
          prdata_ff <= {29'h0, sts_ff};
        end
        if (hit(PADDR, `ELC_IDX_IRQ_MASK)) begin
          prdata_ff <= {29'h0, mask_ff};
        end
      end
    end
  end

  assign PRDATA  = prdata_ff;
  assign PREADY  = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign CH_ON   = ch_on_ff;
  assign TS_SEL  = tsel_ff;
  assign LOG     = log_ff;
  assign IRQ     = irq_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  chk_clear_empties: assert property (clr |=> wptr_ff == 4'h0 && !full_ff ##1 !ne_ff)
    else $error("clear did not empty the queue");
  chk_off_no_store: assert property (!on_ff |=> !log_ff.valid)
    else $error("event stored while recorder off");
  chk_tsel_legal: assert property (tsel_ff == `ELC_TSEL_TIMER1)
    else $error("reserved timestamp source held");
  chk_thresh_flag: assert property (!clr |=> wm_ff == ($past(free_slots) <= {1'b0, $past(thresh_ff)}))
    else $error("threshold flag wrong");
  chk_full_hold: assert property (full_ff && !rptr_wr && !clr |=> full_ff)
    else $error("full flag dropped without read index change");
  chk_full_set: assert property (store && 4'(wptr_ff + 4'h1) == rptr_ff && !clr |=> full_ff)
    else $error("full flag not set on last slot");
  chk_unread_flag: assert property (!clr |=> ne_ff == ($past(wptr_ff) != $past(rptr_ff) || $past(full_ff)))
    else $error("unread flag wrong");
  chk_wptr_step: assert property (store |=> wptr_ff == 4'($past(wptr_ff) + 4'h1) && log_ff.valid)
    else $error("write index did not advance");
  chk_full_discard: assert property (full_ff |-> !store)
    else $error("event stored while full");
  chk_lowest_wins: assert property (store |=> log_ff.channel == $past(win[3:0])
                                   && ($past(pend_ff) & ((16'h0001 << log_ff.channel) - 16'h0001)) == 16'h0000)
    else $error("lower priority channel won");
  chk_level_mirror: assert property (##1 lvl_ff == $past(sync2_ff))
    else $error("channel level not mirrored");
  chk_chan_off: assert property (store |->
                                 (($past(ch_on_ff) >> win[3:0]) & 16'h0001) != 16'h0000)
    else $error("disabled channel stored");
  chk_clear_pending: assert property (clr |=> pend_ff == 16'h0000)
    else $error("clear left events pending");
  chk_off_pending: assert property (!on_ff |=> pend_ff == 16'h0000)
    else $error("events pending while recorder off");
  chk_tsel_frozen: assert property (on_ff |=> tsel_ff == $past(tsel_ff))
    else $error("timestamp source changed while running");
  chk_full_needs_store: assert property (!full_ff && !store |=> !full_ff)
    else $error("full flag set without a store");
  chk_full_release: assert property (rptr_wr && !store && !clr |=> !full_ff)
    else $error("full flag kept after read index change");
  chk_wptr_hold: assert property (!store && !clr |=> wptr_ff == $past(wptr_ff))
    else $error("write index moved without a store");

  // Bus handshake and interrupt level
  // A compliant master never holds setup across two edges, so ready is a single pulse
  chk_ready_single: assert property (pready_ff |=> !pready_ff)
    else $error("ready held longer than one cycle");
  chk_err_with_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("error response without ready");
  chk_irq_raise: assert property ((sts_ff & mask_ff) != 3'h0 |=> irq_ff)
    else $error("unmasked status did not raise interrupt");
  chk_irq_quiet: assert property ((sts_ff & mask_ff) == 3'h0 |=> !irq_ff)
    else $error("interrupt high with nothing unmasked");

  cov_full: cover property (store ##1 full_ff);
  cov_resume: cover property (full_ff ##1 rptr_wr ##1 !full_ff);
  cov_contend: cover property (store && $countones(pend_ff) > 1);
  cov_thresh: cover property (!wm_ff ##1 wm_ff);
  cov_clear: cover property (ne_ff && clr);

endmodule : elc_regs

// >>> event_log_control_regs_bench.sv
// Self-checking bench for the event log control register bank
`timescale 1ns/10ps
`include "elc_params.svh"

module event_log_control_regs_bench;
  import elc_pkg::*;

  logic               SYS_CLK;
  logic               NRST;
  logic               PSEL;
  logic               PENABLE;
  logic               PWRITE;
  logic [23:0]        PADDR;
  logic [31:0]        PWDATA;
  logic [31:0]        PRDATA;
  logic               PREADY;
  logic               PSLVERR;
  logic [15:0]        CH_SRC;
  logic [15:0]        CH_ON;
  logic [1:0]         TS_SEL;
  elc_log_t           LOG;
  logic               IRQ;
  integer             fails;
  integer             n_compared;
  integer             cycles;
  integer             seed;
  integer             i;
  logic [15:0]        rnd;
  logic [32:0]        rd_q[$];
  elc_log_t           log_q[$];

  elc_regs DUT (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
                .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
                .PREADY(PREADY), .PSLVERR(PSLVERR), .CH_SRC(CH_SRC), .CH_ON(CH_ON),
                .TS_SEL(TS_SEL), .LOG(LOG), .IRQ(IRQ));

  always #20 SYS_CLK = ~SYS_CLK;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // An idle edge precedes each setup so the strobes are never assigned twice at once
  task automatic xfer(input logic wr, input logic [19:0] idx, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= {2'h0, idx, 2'h0};
    PWDATA  <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [19:0] idx, input logic [31:0] exp, input logic err);
    rd_q.push_back({err, exp});
    xfer(1'b0, idx, 32'h0);
  endtask : rd

  // One rising level on a channel, held long enough to pass the synchroniser
  task automatic ev(input logic [3:0] ch, input logic logged, input logic [3:0] slot);
    elc_log_t e;
    e = '{valid: 1'b1, index: slot, channel: ch};
    @(posedge SYS_CLK);
    CH_SRC[ch] <= 1'b1;
    if (logged) log_q.push_back(e);
    repeat (8) @(posedge SYS_CLK);
    CH_SRC[ch] <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
  endtask : ev

  // ----------------------------------------
  // Output watcher and timeout
  // ----------------------------------------
  always @(posedge SYS_CLK) begin
    if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1) begin
      check({PSLVERR, PRDATA}, rd_q.pop_front());
    end
    if (LOG.valid === 1'b1) begin
      if (log_q.size() == 0) check(33'(LOG), 33'h0);
      else check(33'(LOG), 33'(log_q.pop_front()));
    end
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      stop_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    SYS_CLK = 1'b0;
    NRST = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 24'h0;
    PWDATA = 32'h0;
    CH_SRC = 16'h0;
    fails = 0;
    n_compared = 0;
    cycles = 0;
    seed = 33735;
    repeat (16) @(posedge SYS_CLK);
    NRST <= 1'b1;
    rd(`ELC_IDX_CTRL, 32'h0, 1'b0);
    rd(`ELC_IDX_TSEL, 32'h0, 1'b0);
    rd(`ELC_IDX_THRESH, 32'h1, 1'b0);
    rd(`ELC_IDX_PTR, 32'h0, 1'b0);
    rd(`ELC_IDX_CH_ON, 32'h0, 1'b0);
    rd(`ELC_IDX_CH_LVL, 32'h0, 1'b0);
    rd(`ELC_IDX_IRQ_STS, 32'h0, 1'b0);
    rd(`ELC_IDX_IRQ_MASK, 32'h0, 1'b0);
    rd(20'h48008, 32'h0, 1'b1);
    $display("test reset values done");
    rnd = 16'($random(seed));
    xfer(1'b1, `ELC_IDX_CH_ON, {16'h0, rnd});
    rd(`ELC_IDX_CH_ON, {16'h0, rnd}, 1'b0);
    check({17'h0, CH_ON}, {17'h0, rnd});
    rnd = 16'($random(seed));
    CH_SRC <= rnd;
    repeat (4) @(posedge SYS_CLK);
    rd(`ELC_IDX_CH_LVL, {16'h0, rnd}, 1'b0);
    CH_SRC <= 16'h0;
    repeat (4) @(posedge SYS_CLK);
    xfer(1'b1, `ELC_IDX_TSEL, 32'h2);
    rd(`ELC_IDX_TSEL, 32'h0, 1'b0);
    check({31'h0, TS_SEL}, 33'h0);
    xfer(1'b1, `ELC_IDX_THRESH, 32'hFFFF_FFFF);
    rd(`ELC_IDX_THRESH, 32'hF, 1'b0);
    $display("test register access done");
    xfer(1'b1, `ELC_IDX_CH_ON, 32'hFFFF);
    xfer(1'b1, `ELC_IDX_CTRL, 32'h1);
    rd(`ELC_IDX_CTRL, 32'h1, 1'b0);
    @(posedge SYS_CLK);
    CH_SRC <= 16'h0024;
    log_q.push_back('{valid: 1'b1, index: 4'h0, channel: 4'h2});
    log_q.push_back('{valid: 1'b1, index: 4'h1, channel: 4'h5});
    repeat (10) @(posedge SYS_CLK);
    CH_SRC <= 16'h0;
    repeat (4) @(posedge SYS_CLK);
    rd(`ELC_IDX_PTR, 32'h3_0200, 1'b0);
    for (i = 2; i < 16; i++) ev(4'h0, 1'b1, 4'(i));
    ev(4'h0, 1'b0, 4'h0);
    rd(`ELC_IDX_PTR, 32'h7_0000, 1'b0);
    xfer(1'b1, `ELC_IDX_PTR, 32'h0);
    rd(`ELC_IDX_PTR, 32'h7_0000, 1'b0);
    xfer(1'b1, `ELC_IDX_PTR, 32'h4);
    rd(`ELC_IDX_PTR, 32'h3_0004, 1'b0);
    ev(4'h3, 1'b1, 4'h0);
    rd(`ELC_IDX_PTR, 32'h3_0104, 1'b0);
    $display("test queue fill and full done");
    rd(`ELC_IDX_IRQ_STS, 32'h7, 1'b0);
    check({32'h0, IRQ}, 33'h0);
    xfer(1'b1, `ELC_IDX_IRQ_MASK, 32'h1);
    repeat (3) @(posedge SYS_CLK);
    check({32'h0, IRQ}, 33'h1);
    xfer(1'b1, `ELC_IDX_IRQ_STS, 32'h1);
    repeat (3) @(posedge SYS_CLK);
    check({32'h0, IRQ}, 33'h0);
    rd(`ELC_IDX_IRQ_STS, 32'h6, 1'b0);
    $display("test interrupt done");
    xfer(1'b1, `ELC_IDX_CTRL, 32'h3);
    rd(`ELC_IDX_CTRL, 32'h1, 1'b0);
    rd(`ELC_IDX_PTR, 32'h0, 1'b0);
    xfer(1'b1, `ELC_IDX_CTRL, 32'h0);
    ev(4'h1, 1'b0, 4'h0);
    rd(`ELC_IDX_PTR, 32'h0, 1'b0);
    $display("test clear and disable done");
    repeat (4) @(posedge SYS_CLK);
    check(33'(log_q.size()), 33'h0);
    check(33'(rd_q.size()), 33'h0);
    stop_test();
  end

endmodule : event_log_control_regs_bench
